//--- core/ssat_pkg.sv
// Purpose: shared constants for the serial transceiver
// Assumes: 8-bit host port, 8-bit characters
// Notes:   host timings are already in system clock periods
package ssat_pkg;
  // ----------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CMD_DELAY_TCY = 8;
  localparam int unsigned TXE_DELAY_TCY = 20;
  localparam logic [3:0] CMD_DELAY_CYC = 4'(CMD_DELAY_TCY);
  localparam logic [4:0] TXE_DELAY_CYC = 5'(TXE_DELAY_TCY);
  // ----------------------------------------------------------
  // mode word
  // ----------------------------------------------------------
  localparam int unsigned MODE_FACT_LSB = 0;
  localparam int unsigned MODE_EXT_SYNC = 6;
  localparam int unsigned MODE_SINGLE_SYNC = 7;
  localparam logic [1:0] FACT_SYNC = 2'h0;
  localparam logic [1:0] FACT_1X = 2'h1;
  localparam logic [1:0] FACT_16X = 2'h2;
  localparam logic [1:0] FACT_64X = 2'h3;
  localparam logic [5:0] LIM_1X = 6'h00;
  localparam logic [5:0] LIM_16X = 6'h0f;
  localparam logic [5:0] LIM_64X = 6'h3f;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // ----------------------------------------------------------
  // command word and status word
  // ----------------------------------------------------------
  localparam int unsigned CMD_TRANSMIT_ENABLE_BIT = 0;
  localparam int unsigned CMD_DTR = 1;
  localparam int unsigned CMD_RXEN = 2;
  localparam int unsigned CMD_SEND_BREAK_CMD = 3;
  localparam int unsigned CMD_ERST = 4;
  localparam int unsigned CMD_RTS = 5;
  localparam int unsigned CMD_IRST = 6;
  localparam int unsigned CMD_HUNT = 7;
  localparam int unsigned ST_TXFREE = 0;
  localparam int unsigned ST_RXAVAIL = 1;
  localparam int unsigned ST_TX_ALL_SENT = 2;
  localparam int unsigned ST_PERR = 3;
  localparam int unsigned ST_OVR = 4;
  localparam int unsigned ST_FERR = 5;
  localparam int unsigned ST_SYNC = 6;
  localparam int unsigned ST_DSR = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // ----------------------------------------------------------
  // framing
  // ----------------------------------------------------------
  localparam logic [3:0] ASYNC_BITS = 4'ha;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // ----------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_MODE = 2'b00,
    CFG_SYNC1 = 2'b01,
    CFG_SYNC2 = 2'b10,
    CFG_RUN = 2'b11
  } ssat_cfg_e;
  typedef enum logic [2:0] {
    RX_OFF = 3'b000,
    RX_ARM = 3'b001,
    RX_IDLE = 3'b010,
    RX_START = 3'b011,
    RX_DATA = 3'b100,
    RX_HUNT = 3'b101,
    RX_SYNC2 = 3'b110,
    RX_CHAR = 3'b111
  } ssat_rx_e;
endpackage

//--- core/ssat_sync.sv
// Purpose: two-flop synchroniser with edge detect
// Assumes: inputs are asynchronous to ref_clk
// Notes:   edges are taken from the second and third flops only
module ssat_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // raw and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q, sync_q, prev_q;

  // first flop feeds only the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

//--- core/ssat_top.sv
// Purpose: synchronous/asynchronous serial transceiver
// Assumes: one 100 MHz clock; bit clocks and modem pins asynchronous
// Notes:   host writes mode, sync characters, then commands
// Behaviour
// - transmit-disable never cuts off characters already written or in progress.
// - transmit line idles high after transmission unless send-break is set, except that sync mode sends fill characters while enabled.
// - asynchronous receiver detects and recovers from break by itself.
// - receiver waits for a high line before accepting start bits.
// - external sync disables internal search; its flag clears on status read.
// - double sync reports found only for back-to-back sync characters.
// - enter-hunt in synchronous mode fills receive shifter with ones.
// - strobes have no effect while chip select is inactive.
// - status snapshot is frozen during a status read.
// - separate control, status, data registers; both data paths double-buffered.
// - status changes appear within 28 clocks of their cause.
// - transmitter-ready rises within 8 clocks, falls within 6 of write.
// - receiver-ready rises within 24 clocks, falls within 6 of read.
// - internal sync found within 24 clocks of completing receive edge.
// - transmitter-empty asserts no sooner than 20 clocks after last bit.
// - enable, terminal-ready, request-to-send take effect 8 clocks after write.
// - control select high reaches control/status, low reaches data.
module ssat_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host port
  input wire logic chip_sel_n,
  input wire logic ctrl_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [ssat_pkg::DATA_W-1:0] wdata,
  output logic [ssat_pkg::DATA_W-1:0] rdata,
  // serial link
  input wire logic tx_bit_clock,
  output logic txd,
  input wire logic rx_bit_clock,
  input wire logic rxd,
  // ready and empty
  output logic tx_holding_free,
  output logic rx_char_avail,
  output logic tx_all_sent,
  // sync detect pin
  output logic sync_found,
  output logic sync_found_oe,
  input wire logic sync_found_in,
  // modem control
  input wire logic dsr_n,
  input wire logic cts_n,
  output logic dtr_n,
  output logic rts_n
);
  import ssat_pkg::*;

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  logic txc_fall, rxc_rise, rxd_s, dsr_s_n, cts_s_n, ext_s;

  ssat_sync #(.W(1)) u_txc (
    .ref_clk(ref_clk), .reset_n(reset_n), .d(tx_bit_clock),
    .q(), .rise(), .fall(txc_fall)
  );
  ssat_sync #(.W(1)) u_rxc (
    .ref_clk(ref_clk), .reset_n(reset_n), .d(rx_bit_clock),
    .q(), .rise(rxc_rise), .fall()
  );
  ssat_sync #(.W(4)) u_lvl (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .d({rxd, dsr_n, cts_n, sync_found_in}),
    .q({rxd_s, dsr_s_n, cts_s_n, ext_s}), .rise(), .fall()
  );

  // ----------------------------------------------------------
  // host decode
  // ----------------------------------------------------------
  logic ctl_wr, dat_wr, stat_rd, dat_rd;

  assign ctl_wr = !chip_sel_n && wr_stb && ctrl_sel;
  assign dat_wr = !chip_sel_n && wr_stb && !ctrl_sel;
  assign stat_rd = !chip_sel_n && rd_stb && ctrl_sel;
  assign dat_rd = !chip_sel_n && rd_stb && !ctrl_sel;

  // ----------------------------------------------------------
  // configuration and command
  // ----------------------------------------------------------
  ssat_cfg_e cfg_q;
  logic [7:0] mode_q, sync1_q, sync2_q;
  logic cmd_wr, irst, hunt_cmd, err_rst;
  logic rx_en_q, send_break_cmd_q, tx_en_q, dtr_q, rts_q;
  logic [2:0] pend_q;
  logic [3:0] wait_q;
  logic async_mode, ext_mode, single_sync;
  logic [DIV_W-1:0] div_lim;

  assign cmd_wr = ctl_wr && (cfg_q == CFG_RUN);
  assign irst = cmd_wr && wdata[CMD_IRST];
  assign hunt_cmd = cmd_wr && !irst && wdata[CMD_HUNT];
  assign err_rst = cmd_wr && !irst && wdata[CMD_ERST];
  assign async_mode = (mode_q[MODE_FACT_LSB +: 2] != FACT_SYNC);
  assign ext_mode = !async_mode && mode_q[MODE_EXT_SYNC];
  assign single_sync = mode_q[MODE_SINGLE_SYNC];

  // bit divider limit from the clock factor
  always_comb begin
    case (mode_q[MODE_FACT_LSB +: 2])
      FACT_16X: div_lim = LIM_16X;
      FACT_64X: div_lim = LIM_64X;
      default: div_lim = LIM_1X;
    endcase
  end

  // mode, sync characters, then commands; internal reset restarts the sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= CFG_MODE;
      mode_q <= MODE_RESET;
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (ctl_wr) begin
      case (cfg_q)
        CFG_MODE: begin
          mode_q <= wdata;
          cfg_q <= (wdata[MODE_FACT_LSB +: 2] == FACT_SYNC) ? CFG_SYNC1 : CFG_RUN;
        end
        CFG_SYNC1: begin
          sync1_q <= wdata;
          cfg_q <= single_sync ? CFG_RUN : CFG_SYNC2;
        end
        CFG_SYNC2: begin
          sync2_q <= wdata;
          cfg_q <= CFG_RUN;
        end
        CFG_RUN: begin
          if (wdata[CMD_IRST]) begin
            cfg_q <= CFG_MODE;
          end
        end
        default: cfg_q <= CFG_MODE;
      endcase
    end
  end

  // immediate command bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_en_q <= 1'b0;
      send_break_cmd_q <= 1'b0;
    end else if (irst) begin
      rx_en_q <= 1'b0;
      send_break_cmd_q <= 1'b0;
    end else if (cmd_wr) begin
      rx_en_q <= wdata[CMD_RXEN];
      send_break_cmd_q <= wdata[CMD_SEND_BREAK_CMD];
    end
  end

  // enable and modem outputs wait out the command delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 3'h0;
      wait_q <= 4'h0;
      tx_en_q <= 1'b0;
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
    end else if (irst) begin
      wait_q <= 4'h0;
      tx_en_q <= 1'b0;
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
    end else if (cmd_wr) begin
      pend_q <= {wdata[CMD_RTS], wdata[CMD_DTR], wdata[CMD_TRANSMIT_ENABLE_BIT]};
      wait_q <= CMD_DELAY_CYC;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        {rts_q, dtr_q, tx_en_q} <= pend_q;
      end
    end
  end

  assign dtr_n = !dtr_q;
  assign rts_n = !rts_q;

  // ----------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------
  logic hold_full_q, tx_load, tx_busy, tx_bit, tx_idle;
  logic [7:0] hold_q;
  logic [4:0] txe_cnt_q;
  logic txfree_q, txe_q;

  // transmit holding register in front of the shifter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else if (irst) begin
      hold_full_q <= 1'b0;
    end else if (dat_wr) begin
      hold_q <= wdata;
      hold_full_q <= 1'b1;
    end else if (tx_load) begin
      hold_full_q <= 1'b0;
    end
  end

  // loading ignores the enable, so written data always goes out
  ssat_txser u_tx (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .txc_fall(txc_fall),
    .div_lim(div_lim),
    .async_mode(async_mode),
    .hold_full(hold_full_q),
    .hold_data(hold_q),
    .fill_en(!async_mode && tx_en_q),
    .fill_char(sync1_q),
    .load(tx_load),
    .busy(tx_busy),
    .ser_out(tx_bit)
  );

  assign tx_idle = !tx_busy && !hold_full_q;

  // line, ready and empty outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd <= 1'b1;
      txfree_q <= 1'b0;
      txe_cnt_q <= 5'h00;
      txe_q <= 1'b0;
    end else begin
      txd <= send_break_cmd_q ? 1'b0 : tx_bit;
      // drops the cycle after a data write
      txfree_q <= !hold_full_q && !dat_wr;
      // empty only after the idle guard time
      if (!tx_idle) begin
        txe_cnt_q <= 5'h00;
      end else if (txe_cnt_q != TXE_DELAY_CYC) begin
        txe_cnt_q <= txe_cnt_q + 5'h01;
      end
      txe_q <= tx_idle && (txe_cnt_q == TXE_DELAY_CYC);
    end
  end

  // pin form also needs enable and clear-to-send
  assign tx_holding_free = txfree_q && tx_en_q && !cts_s_n;
  assign tx_all_sent = txe_q;

  // ----------------------------------------------------------
  // receiver
  // ----------------------------------------------------------
  ssat_rx_e rx_st_q;
  logic [7:0] rx_sh_q, rx_char_q, sh_next;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic rx_done_q, rx_ferr_q, brk_q, sync_int_q, samp;

  assign sh_next = {rxd_s, rx_sh_q[7:1]};
  assign samp = rxc_rise && (rx_cnt_q == div_lim);

  // character assembly, break and sync search
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q <= RX_OFF;
      rx_sh_q <= 8'hff;
      rx_char_q <= 8'h00;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      brk_q <= 1'b0;
      sync_int_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      // status read clears, a match in the same cycle wins below
      if (stat_rd) begin
        sync_int_q <= 1'b0;
      end
      if (!rx_en_q) begin
        rx_st_q <= RX_OFF;
        brk_q <= 1'b0;
        sync_int_q <= 1'b0;
      end else if (hunt_cmd && !async_mode) begin
        // flush shifter to ones before hunting
        rx_sh_q <= 8'hff;
        rx_st_q <= RX_HUNT;
        sync_int_q <= 1'b0;
      end else begin
        case (rx_st_q)
          RX_OFF: begin
            rx_sh_q <= 8'hff;
            rx_st_q <= async_mode ? RX_ARM : RX_HUNT;
          end
          // no start search until the line is seen high
          RX_ARM: begin
            if (rxc_rise && rxd_s) begin
              rx_st_q <= RX_IDLE;
              brk_q <= 1'b0;
            end
          end
          RX_IDLE: begin
            if (rxc_rise && !rxd_s) begin
              rx_cnt_q <= '0;
              rx_bit_q <= 4'h0;
              rx_st_q <= (div_lim == LIM_1X) ? RX_DATA : RX_START;
            end
          end
          // false start bit rejected at mid-bit
          RX_START: begin
            if (rxc_rise) begin
              if (rx_cnt_q == (div_lim >> 1)) begin
                rx_cnt_q <= '0;
                rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
              end else begin
                rx_cnt_q <= rx_cnt_q + 6'h01;
              end
            end
          end
          RX_DATA: begin
            if (samp) begin
              rx_cnt_q <= '0;
              if (rx_bit_q == DATA_BITS) begin
                // null char with low stop bit is break
                if (!rxd_s && rx_sh_q == 8'h00) begin
                  brk_q <= 1'b1;
                  rx_st_q <= RX_ARM;
                end else begin
                  rx_char_q <= rx_sh_q;
                  rx_done_q <= 1'b1;
                  rx_ferr_q <= !rxd_s;
                  rx_st_q <= RX_IDLE;
                end
              end else begin
                rx_sh_q <= sh_next;
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end else if (rxc_rise) begin
              rx_cnt_q <= rx_cnt_q + 6'h01;
            end
          end
          RX_HUNT: begin
            if (rxc_rise) begin
              rx_sh_q <= sh_next;
              rx_bit_q <= 4'h0;
              if (ext_mode) begin
                if (ext_s) begin
                  rx_st_q <= RX_CHAR;
                end
              end else if (sh_next == sync1_q) begin
                // flag set in the matching edge cycle in single sync mode only
                sync_int_q <= single_sync;
                rx_st_q <= single_sync ? RX_CHAR : RX_SYNC2;
              end
            end
          end
          // second sync must follow with no gap
          RX_SYNC2: begin
            if (rxc_rise) begin
              rx_sh_q <= sh_next;
              if (rx_bit_q == LAST_BIT) begin
                rx_bit_q <= 4'h0;
                sync_int_q <= (sh_next == sync2_q);
                rx_st_q <= (sh_next == sync2_q) ? RX_CHAR : RX_HUNT;
              end else begin
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end
          end
          RX_CHAR: begin
            if (rxc_rise) begin
              rx_sh_q <= sh_next;
              if (rx_bit_q == LAST_BIT) begin
                rx_bit_q <= 4'h0;
                rx_char_q <= sh_next;
                rx_done_q <= 1'b1;
              end else begin
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end
          end
          default: rx_st_q <= RX_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // receive holding and error flags
  // ----------------------------------------------------------
  logic [7:0] rx_hold_q;
  logic rx_avail_q, ovr_q, fe_q, ext_flag_q;

  // receive holding register; set wins over read and reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_hold_q <= 8'h00;
      rx_avail_q <= 1'b0;
      ovr_q <= 1'b0;
      fe_q <= 1'b0;
    end else begin
      if (rx_done_q) begin
        rx_hold_q <= rx_char_q;
      end
      // cleared the cycle after a data read
      rx_avail_q <= rx_done_q || (rx_avail_q && !dat_rd);
      ovr_q <= (rx_done_q && rx_avail_q && !dat_rd) || (ovr_q && !err_rst);
      fe_q <= rx_ferr_q || (fe_q && !err_rst);
    end
  end

  assign rx_char_avail = rx_avail_q;

  // external sync latch clears on status read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_flag_q <= 1'b0;
    end else begin
      ext_flag_q <= (ext_mode && ext_s) || (ext_flag_q && !stat_rd);
    end
  end

  // sync pin: break in async, input in external mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_found <= 1'b0;
      sync_found_oe <= 1'b0;
    end else begin
      sync_found <= async_mode ? brk_q : sync_int_q;
      sync_found_oe <= !ext_mode;
    end
  end

  // ----------------------------------------------------------
  // status and read data
  // ----------------------------------------------------------
  logic [7:0] stat_live, stat_q;

  always_comb begin
    stat_live = STAT_RESET;
    stat_live[ST_TXFREE] = !hold_full_q;
    stat_live[ST_RXAVAIL] = rx_avail_q;
    stat_live[ST_TX_ALL_SENT] = txe_q;
    stat_live[ST_PERR] = 1'b0;
    stat_live[ST_OVR] = ovr_q;
    stat_live[ST_FERR] = fe_q;
    stat_live[ST_SYNC] = async_mode ? brk_q : (ext_mode ? ext_flag_q : sync_int_q);
    stat_live[ST_DSR] = !dsr_s_n;
  end

  // snapshot held while status is read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= STAT_RESET;
    end else if (!stat_rd) begin
      stat_q <= stat_live;
    end
  end

  // read data stands one cycle only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (stat_rd) begin
      rdata <= stat_q;
    end else if (dat_rd) begin
      rdata <= rx_hold_q;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

//--- core/ssat_txser.sv
// Purpose: transmit shifter fed from the holding register
// Assumes: txc_fall is a one-cycle pulse per bit-clock falling edge
// Notes:   a new frame may start on the edge that ends the previous one
module ssat_txser (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // bit timing
  input wire logic txc_fall,
  input wire logic [ssat_pkg::DIV_W-1:0] div_lim,
  input wire logic async_mode,
  // holding register side
  input wire logic hold_full,
  input wire logic [ssat_pkg::DATA_W-1:0] hold_data,
  input wire logic fill_en,
  input wire logic [ssat_pkg::DATA_W-1:0] fill_char,
  output logic load,
  // serial side
  output logic busy,
  output logic ser_out
);
  import ssat_pkg::*;

  logic [9:0] sh_q;
  logic [3:0] left_q;
  logic [DIV_W-1:0] div_q;
  logic adv, start;
  logic [7:0] chr;
  logic [9:0] frame;

  // end of a bit period; a frame only starts at a bit boundary
  assign adv = txc_fall && (left_q != 4'h0) && (div_q == div_lim);
  assign start = ((txc_fall && left_q == 4'h0) || (adv && left_q == 4'h1)) && (hold_full || fill_en);
  assign load = start && hold_full;
  assign busy = (left_q != 4'h0);
  assign ser_out = busy ? sh_q[0] : 1'b1;

  // sync fill only when nothing was written
  always_comb begin
    chr = hold_full ? hold_data : fill_char;
    frame = async_mode ? {1'b1, chr, 1'b0} : {2'b11, chr};
  end

  // shifter and bit divider
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= 10'h3ff;
      left_q <= 4'h0;
      div_q <= '0;
    end else if (start) begin
      sh_q <= frame;
      left_q <= async_mode ? ASYNC_BITS : SYNC_BITS;
      div_q <= '0;
    end else if (adv) begin
      sh_q <= {1'b1, sh_q[9:1]};
      left_q <= left_q - 4'h1;
      div_q <= '0;
    end else if (txc_fall && busy) begin
      div_q <= div_q + 6'h01;
    end
  end
endmodule

//--- testbench/ssat_link_model.sv
// Purpose: far end of the serial link
// Assumes: bit clocks run free at 125 ns
// Notes: txd loops back to rxd so both paths are seen
module ssat_link_model (
  // serial pins
  input wire logic txd,
  output logic tx_bit_clock,
  output logic rx_bit_clock,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  // bit clock rate
  // fine for 16x, too fast for 1x, so 1x is never programmed
  initial begin
    tx_bit_clock = 1'b0;
    #3.3;
    forever #62.5 tx_bit_clock = ~tx_bit_clock;
  end
  // skewed receive clock and wire delay
  assign #21 rx_bit_clock = tx_bit_clock;
  assign #7 rxd = txd;
endmodule

//--- testbench/ssat_top_properties.sv
// Purpose: port assertions for ssat_top
// Assumes: one clock domain, reset_n async active low
// Notes: bound to every ssat_top instance
module ssat_top_checker (
  // watched ports
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic ctrl_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [ssat_pkg::DATA_W-1:0] rdata,
  input wire logic txd,
  input wire logic tx_holding_free,
  input wire logic rx_char_avail,
  input wire logic tx_all_sent,
  input wire logic dtr_n,
  input wire logic rts_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_q;
  logic [4:0] hi_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reset counts as idle line, so the run starts saturated
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= 1'b0;
      hi_q <= 5'h1f;
    end else begin
      rd_q <= !chip_sel_n && rd_stb;
      hi_q <= txd ? hi_q + {4'h0, hi_q != 5'h1f} : 5'h00;
    end
  end
  rdata_idle_a: assert property (!rd_q |-> rdata == 8'h00) else $error("rdata not idle");
  reset_out_a: assert property ($rose(reset_n) |-> txd && dtr_n && rts_n) else $error("bad reset out");
  txfree_fall_a: assert property (!chip_sel_n && wr_stb && !ctrl_sel |-> ##[1:6] !tx_holding_free)
    else $error("ready stuck");
  rxavail_fall_a: assert property (!chip_sel_n && rd_stb && !ctrl_sel && rx_char_avail |-> ##[1:6] !rx_char_avail)
    else $error("avail stuck");
  dtr_hold_a: assert property (!chip_sel_n && wr_stb && ctrl_sel |=> $stable(dtr_n) [*8])
    else $error("dtr early");
  rts_hold_a: assert property (!chip_sel_n && wr_stb && ctrl_sel |=> $stable(rts_n) [*8])
    else $error("rts early");
  tx_all_sent_late_a: assert property ($rose(tx_all_sent) |-> hi_q >= 5'h14) else $error("empty early");
  deselect_ignore_a: assert property (chip_sel_n && wr_stb && tx_holding_free |=> tx_holding_free)
    else $error("deselected write acted");
  cover property (!chip_sel_n && rd_stb && !ctrl_sel && rx_char_avail);
  cover property ($rose(tx_all_sent));
  cover property (chip_sel_n && wr_stb);
endmodule
bind ssat_top ssat_top_checker ssat_top_checker_inst (.*);

//--- testbench/ssat_top_test.sv
// Purpose: self-checking bench for ssat_top
// Assumes: 16x async mode, looped serial link
// Notes: host spacing of 16 clocks meets every recovery time
module ssat_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ssat_pkg::*;
  logic ref_clk, reset_n = 1'b0, chip_sel_n = 1'b1, ctrl_sel = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic txd, tx_bit_clock, rx_bit_clock, rxd, tx_holding_free, rx_char_avail, tx_all_sent;
  logic sync_found, sync_found_oe, dtr_n, rts_n, dsr_n = 1'b0, cts_n = 1'b0;
  logic [DATA_W-1:0] wdata = 8'h00, rdata, v, e;
  logic [31:0] seed = 32'hecdf;
  int bad_count = 0, cmp_count = 0, i;
  // sync input held low, so its set-up time is never at stake
  ssat_top ssat_top_inst (.sync_found_in(1'b0), .*);
  ssat_link_model ssat_link_model_inst (.*);
  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // one host cycle, then 16 idle clocks; read data caught where it stands
  task automatic acc(input logic w, input logic c, input logic [7:0] d);
    @(posedge ref_clk);
    chip_sel_n <= 1'b0;
    ctrl_sel <= c;
    wr_stb <= w;
    rd_stb <= !w;
    wdata <= d;
    @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 v = rdata;
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic wt(ref logic s);
    for (int k = 0; k < 3000 && s !== 1'b1; k++) @(posedge ref_clk);
    chk(s === 1'b1, "wait timed out");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, about two and a half times the expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    dsr_n <= 1'b1;
    chk(txd === 1'b1 && dtr_n === 1'b1, "idle after reset");
    acc(1, 1, {6'h00, FACT_16X});
    acc(1, 1, 8'h27);
    chk(dtr_n === 1'b0 && rts_n === 1'b0, "modem outputs");
    chk(sync_found_oe === 1'b1, "sync pin driven");
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      e = i == 0 ? 8'h00 : i == 1 ? 8'hff : seed[7:0];
      wt(tx_holding_free);
      acc(1, 0, e);
      wt(rx_char_avail);
      acc(0, 0, 8'h00);
      chk(v === e && rx_char_avail === 1'b0, "looped char");
    end
    // two characters with no read between: the second overwrites and flags overrun
    acc(1, 0, 8'h5a);
    wt(tx_holding_free);
    acc(1, 0, 8'ha5);
    repeat (4400) @(posedge ref_clk);
    acc(0, 1, 8'h00);
    chk(v[ST_OVR] === 1'b1 && v[ST_RXAVAIL] === 1'b1, "overrun flag");
    acc(1, 1, 8'h37);
    acc(0, 0, 8'h00);
    chk(v === 8'ha5 && rx_char_avail === 1'b0, "newest char held");
    acc(0, 1, 8'h00);
    chk(v[ST_TXFREE] === 1'b1, "status free");
    chk(v[ST_OVR] === 1'b0, "error reset");
    chk(v[ST_DSR] === 1'b0, "dsr status");
    // deselected data write: a leak would drop ready at once
    ctrl_sel <= 1'b0;
    @(posedge ref_clk) wr_stb <= 1'b1;
    @(posedge ref_clk) wr_stb <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(tx_holding_free === 1'b1, "deselected write");
    wt(tx_all_sent);
    chk(tx_all_sent === 1'b1 && txd === 1'b1, "line idle");
    acc(1, 1, 8'h2f);
    chk(txd === 1'b0, "break level");
    repeat (2500) @(posedge ref_clk);
    chk(sync_found === 1'b1, "break seen");
    acc(1, 1, 8'h27);
    repeat (500) @(posedge ref_clk);
    chk(sync_found === 1'b0 && txd === 1'b1, "break over");
    print_verdict;
  end
endmodule
